// ---- core/serial_port_regs.svh ----
/*
 constants of the three-pin serial register port: frame layout, register file, timing.
 assumes inclusion by bare name from every file that needs them.
*/
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// frame layout, in active clock edges; EDGE_LAST counts every clock edge, the pair values count edge pairs
`define HDR_LAST 5'h07
`define HDR_EDGES 5'h08
`define DATA_LAST 5'h0F
`define FRAME_EDGES 5'h10
`define EDGE_LAST 5'h1F
`define RELEASE_PAIR 4'h7
`define READ_PAIR_FIRST 4'h8

// header byte fields
`define HDR_DIR_BIT 7
`define HDR_SEL_MSB 6
`define HDR_SEL_LSB 4
`define HDR_ADDR_MSB 3
`define HDR_ADDR_LSB 0

// register file
`define REG_COUNT 16
`define REG_CLEAR 8'h00
`define CTRL_REG 4'h5
`define MODE_BIT 7

// timing
`define CLK_NS 20
`define SCLK_HALF_NS 160

`endif

// ---- core/serial_port_pkg.sv ----
/*
 types shared by both ends of the serial register port.
 assumes serial_port_regs.svh for the numeric constants.
*/
`default_nettype none

package serial_port_pkg;
    typedef logic [3:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef logic [2:0] dev_code_t;
    typedef logic [4:0] edge_cnt_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_LEAD = 2'h1,
        H_RUN = 2'h3,
        H_TAIL = 2'h2
    } host_state_e;
endpackage

`default_nettype wire

// ---- core/serial_port_if.sv ----
/*
 link between host and device: clock, active-low enable and the shared data line.
 assumes the testbench instantiates it twice, one link per device, and connects the ends; the data line is resolved here.
*/
`timescale 1ns/100ps
`default_nettype none

interface serial_port_if;
    logic serial_clock;
    logic serial_enable_line_n;
    logic host_data_out;
    logic host_data_oe_n;
    logic dev_data_out;
    logic dev_data_oe_n;
    logic serial_data_line;

    // host wins a clash, an undriven line reads low through the pulldown
    assign serial_data_line = !host_data_oe_n ? host_data_out : (!dev_data_oe_n ? dev_data_out : 1'b0);

    modport device (
        input serial_clock,
        input serial_enable_line_n,
        input serial_data_line,
        output dev_data_out,
        output dev_data_oe_n
    );

    modport host (
        output serial_clock,
        output serial_enable_line_n,
        output host_data_out,
        output host_data_oe_n,
        input serial_data_line
    );
endinterface

`default_nettype wire

// ---- core/serial_port_device.sv ----
/*
 device end of the three-pin serial register port with its sixteen 8-bit registers.
 assumes CLK is much faster than the serial clock and that the host keeps its own timing.
*/
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"

module serial_port_device #(
    // arbitrary select code of this device
    parameter serial_port_pkg::dev_code_t DEVICE_CODE = 3'h5
) (
    // system
    input wire logic CLK,
    input wire logic SRST,
    // serial link
    serial_port_if.device LINK,
    // register write report
    output var logic WR_STROBE,
    output var serial_port_pkg::reg_addr_t WR_ADDR,
    output var serial_port_pkg::reg_data_t WR_DATA,
    // current edge convention
    output var logic MODE_INV
);
    import serial_port_pkg::*;

    reg_data_t regs_q [`REG_COUNT];
    logic clk_m;
    logic clk_s;
    logic clk_p;
    logic en_m;
    logic en_s;
    logic dat_m;
    logic dat_s;
    logic mode_q;
    edge_cnt_t cnt_q;
    logic [15:0] rx_q;
    logic [15:0] rx_d;
    reg_data_t hdr_q;
    logic rd_arm_q;
    logic oe_n_q;
    reg_data_t tx_q;
    logic rise;
    logic fall;
    logic act_edge;
    logic launch_edge;
    logic shift_win;
    edge_cnt_t mode_ext;

    function automatic logic selects(input reg_data_t hdr, input dev_code_t code);
        selects = (hdr[`HDR_SEL_MSB:`HDR_SEL_LSB] == code);
    endfunction

    // pin synchronisers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            // idle level of the default convention, so no false edge after reset
            clk_m <= 1'b1;
            clk_s <= 1'b1;
            clk_p <= 1'b1;
            en_m <= 1'b1;
            en_s <= 1'b1;
            dat_m <= 1'b0;
            dat_s <= 1'b0;
        end else begin
            clk_m <= LINK.serial_clock;
            clk_s <= clk_m;
            clk_p <= clk_s;
            en_m <= LINK.serial_enable_line_n;
            en_s <= en_m;
            dat_m <= LINK.serial_data_line;
            dat_s <= dat_m;
        end
    end

    assign rise = clk_s & ~clk_p;
    assign fall = ~clk_s & clk_p;
    // only edges after the enable fall count, whatever level the clock started at
    assign act_edge = ~en_s & (mode_q ? rise : fall) & (cnt_q < `FRAME_EDGES);
    assign launch_edge = ~en_s & (mode_q ? fall : rise);
    assign rx_d = {rx_q[14:0], dat_s};
    assign mode_ext = {4'h0, mode_q};
    // default shifts after falls 9..15, inverted presents on rises 10..16
    assign shift_win = (cnt_q >= (`HDR_EDGES + mode_ext)) && (cnt_q < (`DATA_LAST + mode_ext));

    // edge convention, held for the whole frame
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mode_q <= 1'b0;
        end else if (en_s) begin
            mode_q <= regs_q[`CTRL_REG][`MODE_BIT];
        end
    end

    // edge counter, cleared whenever the enable is high
    always_ff @(posedge CLK) begin
        if (SRST || en_s) begin
            cnt_q <= 5'h00;
        end else if (act_edge) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // receive shifter and header capture
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rx_q <= 16'h0000;
            hdr_q <= `REG_CLEAR;
        end else if (act_edge) begin
            rx_q <= rx_d;
            if (cnt_q == `HDR_LAST) begin
                hdr_q <= rx_d[7:0];
            end
        end
    end

    // register file
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs_q[i] <= `REG_CLEAR;
            end
        end else if (act_edge && cnt_q == `DATA_LAST && !hdr_q[`HDR_DIR_BIT] && selects(hdr_q, DEVICE_CODE)) begin
            regs_q[hdr_q[`HDR_ADDR_MSB:`HDR_ADDR_LSB]] <= rx_d[7:0];
        end
    end

    // write report
    always_ff @(posedge CLK) begin
        if (SRST) begin
            WR_STROBE <= 1'b0;
            WR_ADDR <= 4'h0;
            WR_DATA <= `REG_CLEAR;
            MODE_INV <= 1'b0;
        end else begin
            WR_STROBE <= act_edge && cnt_q == `DATA_LAST && !hdr_q[`HDR_DIR_BIT] && selects(hdr_q, DEVICE_CODE);
            if (act_edge && cnt_q == `DATA_LAST) begin
                WR_ADDR <= hdr_q[`HDR_ADDR_MSB:`HDR_ADDR_LSB];
                WR_DATA <= rx_d[7:0];
            end
            MODE_INV <= mode_q;
        end
    end

    // read arming after the last address bit
    always_ff @(posedge CLK) begin
        if (SRST || en_s) begin
            rd_arm_q <= 1'b0;
        end else if (act_edge && cnt_q == `HDR_LAST) begin
            rd_arm_q <= rx_d[`HDR_DIR_BIT] && selects(rx_d[7:0], DEVICE_CODE);
        end
    end

    // line ownership
    always_ff @(posedge CLK) begin
        if (SRST || en_s) begin
            oe_n_q <= 1'b1;
        end else if (rd_arm_q && launch_edge) begin
            oe_n_q <= 1'b0;
        end
    end

    // read shifter, msb first, never tri-stated between bits
    always_ff @(posedge CLK) begin
        if (SRST) begin
            tx_q <= `REG_CLEAR;
        end else if (act_edge && cnt_q == `HDR_LAST) begin
            tx_q <= regs_q[rx_d[`HDR_ADDR_MSB:`HDR_ADDR_LSB]];
        end else if (act_edge && rd_arm_q && shift_win) begin
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign LINK.dev_data_out = tx_q[7];
    assign LINK.dev_data_oe_n = oe_n_q;
endmodule

`default_nettype wire

// ---- core/serial_port_host.sv ----
/*
 host end of the serial register port: makes the serial clock and enable, runs one frame per request.
 assumes the user sets MODE_INV to match the device's current edge convention.
*/
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"

module serial_port_host #(
    parameter int HALF_CYCLES = `SCLK_HALF_NS / `CLK_NS
) (
    // system
    input wire logic CLK,
    input wire logic SRST,
    // request
    input wire logic START,
    input wire logic READ,
    input wire logic MODE_INV,
    input wire serial_port_pkg::dev_code_t SEL_CODE,
    input wire serial_port_pkg::reg_addr_t ADDR,
    input wire serial_port_pkg::reg_data_t WDATA,
    // answer
    output var logic BUSY,
    output var logic DONE,
    output var serial_port_pkg::reg_data_t RDATA,
    // serial link
    serial_port_if.host LINK
);
    import serial_port_pkg::*;

    host_state_e state_q;
    logic [7:0] div_q;
    logic tick;
    edge_cnt_t e_q;
    logic rd_q;
    logic [15:0] tx_q;
    reg_data_t rx_q;
    logic sclk_q;
    logic sen_n_q;
    logic hout_q;
    logic hoe_n_q;
    logic dat_m;
    logic dat_s;
    logic run_tick;

    assign tick = (div_q == 8'(HALF_CYCLES - 1));
    assign run_tick = (state_q == H_RUN) && tick;

    // read data synchroniser
    always_ff @(posedge CLK) begin
        if (SRST) begin
            dat_m <= 1'b0;
            dat_s <= 1'b0;
        end else begin
            dat_m <= LINK.serial_data_line;
            dat_s <= dat_m;
        end
    end

    // half-period divider
    always_ff @(posedge CLK) begin
        if (SRST || state_q == H_IDLE || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // frame sequencer
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_q <= H_IDLE;
            e_q <= 5'h00;
            BUSY <= 1'b0;
            DONE <= 1'b0;
        end else begin
            DONE <= 1'b0;
            unique case (state_q)
                H_IDLE: begin
                    e_q <= 5'h00;
                    if (START) begin
                        state_q <= H_LEAD;
                        BUSY <= 1'b1;
                    end
                end
                H_LEAD: begin
                    if (tick) begin
                        state_q <= H_RUN;
                    end
                end
                H_RUN: begin
                    if (tick) begin
                        e_q <= e_q + 5'h01;
                        if (e_q == `EDGE_LAST) begin
                            state_q <= H_TAIL;
                        end
                    end
                end
                H_TAIL: begin
                    if (tick) begin
                        state_q <= H_IDLE;
                        BUSY <= 1'b0;
                        DONE <= 1'b1;
                    end
                end
            endcase
        end
    end

    // clock and enable pins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sclk_q <= 1'b1;
            sen_n_q <= 1'b1;
        end else if (state_q == H_IDLE) begin
            sclk_q <= ~MODE_INV;
            sen_n_q <= ~START;
        end else if (run_tick) begin
            sclk_q <= ~sclk_q;
            if (e_q == `EDGE_LAST) begin
                sen_n_q <= 1'b1;
            end
        end
    end

    // outgoing bits change on launch edges, line freed after the eighth active edge of a read, at frame end for a write
    always_ff @(posedge CLK) begin
        if (SRST) begin
            tx_q <= 16'h0000;
            rd_q <= 1'b0;
            hout_q <= 1'b0;
            hoe_n_q <= 1'b1;
        end else if (state_q == H_IDLE) begin
            hoe_n_q <= ~START;
            if (START) begin
                tx_q <= {READ, SEL_CODE, ADDR, WDATA};
                rd_q <= READ;
                hout_q <= READ;
            end
        end else if (run_tick && e_q[0]) begin
            tx_q <= {tx_q[14:0], 1'b0};
            hout_q <= tx_q[14];
            if (rd_q && e_q[4:1] == `RELEASE_PAIR) begin
                hoe_n_q <= 1'b1;
            end
            if (e_q == `EDGE_LAST) begin
                hoe_n_q <= 1'b1;
            end
        end
    end

    // read bits captured on falling edges nine to sixteen
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rx_q <= `REG_CLEAR;
            RDATA <= `REG_CLEAR;
        end else begin
            if (run_tick && sclk_q && rd_q && e_q[4:1] >= `READ_PAIR_FIRST) begin
                rx_q <= {rx_q[6:0], dat_s};
            end
            if (state_q == H_TAIL && tick && rd_q) begin
                RDATA <= rx_q;
            end
        end
    end

    assign LINK.serial_clock = sclk_q;
    assign LINK.serial_enable_line_n = sen_n_q;
    assign LINK.host_data_out = hout_q;
    assign LINK.host_data_oe_n = hoe_n_q;
endmodule

`default_nettype wire

// ---- core/serial_port_pkg_unused_guard.sv ----
/*
 intentionally empty compile unit kept out of the build.
 assumes nothing.
*/

// ---- test/serial_port_properties.sv ----
/*
 concurrent checks on the link between host and device.
 assumes one clock domain CLK with synchronous SRST, instantiated beside the link.
*/
`timescale 1ns/100ps
`default_nettype none

module serial_port_properties (
    // system
    input wire logic CLK,
    input wire logic SRST,
    // link
    input wire logic serial_clock,
    input wire logic serial_enable_line_n,
    input wire logic host_data_out,
    input wire logic host_data_oe_n,
    input wire logic dev_data_out,
    input wire logic dev_data_oe_n
);
    logic sclk_q, sen_q;
    logic [5:0] tog_q;

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    // delayed link levels
    always_ff @(posedge CLK) begin
        sclk_q <= serial_clock;
        sen_q <= serial_enable_line_n;
    end

    // clock toggles seen within a frame
    always_ff @(posedge CLK) begin
        if (SRST || (serial_enable_line_n && sen_q)) begin
            tog_q <= 6'h00;
        end else if (!sen_q && serial_clock != sclk_q) begin
            tog_q <= tog_q + 6'h01;
        end
    end

    a_frame_edges: assert property ($rose(serial_enable_line_n) |=> tog_q == 6'h20)
        else $error("frame length not 32 clock toggles");
    a_take_after_eighth: assert property ($fell(dev_data_oe_n) |-> tog_q == 6'h10)
        else $error("device took line at wrong edge");
    a_take_in_frame: assert property ($fell(dev_data_oe_n) |-> !serial_enable_line_n && host_data_oe_n)
        else $error("device took line outside a read");
    a_no_bus_clash: assert property (!(!host_data_oe_n && !dev_data_oe_n))
        else $error("both ends drive the data line");
    a_drive_steady: assert property (!dev_data_oe_n && !serial_enable_line_n |=> !dev_data_oe_n)
        else $error("device released line between bits");
    a_release_idle: assert property (serial_enable_line_n [*5] |-> dev_data_oe_n)
        else $error("device still drives after frame end");
    a_host_launch: assert property (!serial_enable_line_n && !sen_q && !host_data_oe_n
        && $changed(host_data_out) |-> serial_clock != sclk_q)
        else $error("host data changed away from a clock edge");
    a_dev_bit_hold: assert property (!serial_enable_line_n && !dev_data_oe_n
        && $changed(dev_data_out) |=> $stable(dev_data_out) [*6])
        else $error("device read bit changed too soon");
endmodule

`default_nettype wire

// ---- test/tb.sv ----
/*
 testbench: host and device on one link, a second device on a link driven here.
 assumes package, header, interface and design files compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"

module tb;
    import serial_port_pkg::*;
    localparam dev_code_t CODE = 3'h5; // arbitrary select code
    logic clk, srst, start, rd, mode_inv, busy, done, wr_strobe, dev_mode, wr_strobe2, mode2;
    dev_code_t sel_code;
    reg_addr_t addr, wr_addr, wr_addr2;
    reg_data_t wdata, rdata, wr_data, wr_data2;
    int error_cnt = 0;
    int cmp_count = 0;
    int n_stb = 0;
    int n_stb2 = 0;

    serial_port_if lnk ();
    serial_port_if lnk2 ();
    serial_port_host #(.HALF_CYCLES(8)) i_serial_port_host (.CLK(clk), .SRST(srst), .START(start),
        .READ(rd), .MODE_INV(mode_inv), .SEL_CODE(sel_code), .ADDR(addr), .WDATA(wdata), .BUSY(busy),
        .DONE(done), .RDATA(rdata), .LINK(lnk.host));
    serial_port_device #(.DEVICE_CODE(CODE)) i_serial_port_device (.CLK(clk), .SRST(srst),
        .LINK(lnk.device), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .MODE_INV(dev_mode));
    serial_port_device #(.DEVICE_CODE(CODE)) i_serial_port_device_2 (.CLK(clk), .SRST(srst),
        .LINK(lnk2.device), .WR_STROBE(wr_strobe2), .WR_ADDR(wr_addr2), .WR_DATA(wr_data2), .MODE_INV(mode2));
    serial_port_properties i_props (.CLK(clk), .SRST(srst), .serial_clock(lnk.serial_clock),
        .serial_enable_line_n(lnk.serial_enable_line_n), .host_data_out(lnk.host_data_out),
        .host_data_oe_n(lnk.host_data_oe_n), .dev_data_out(lnk.dev_data_out), .dev_data_oe_n(lnk.dev_data_oe_n));

    always #10 clk = ~clk;

    // write strobe counters
    always @(posedge clk) begin
        if (wr_strobe === 1'b1) n_stb++;
        if (wr_strobe2 === 1'b1) n_stb2++;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one host frame, waits for its completion
    task automatic xfer(logic r, dev_code_t c, reg_addr_t a, reg_data_t d);
        int i;
        @(posedge clk);
        start <= 1'b1;
        rd <= r;
        sel_code <= c;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        start <= 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (i == 0) chk("busy", 8'h01, {7'h00, busy});
            if (done === 1'b1) break;
        end
        if (i == 400) begin
            error_cnt++;
            $display("wrong value done expected 1 seen 0");
            finish_test();
        end
        chk("busy end", 8'h00, {7'h00, busy});
    endtask

    // bench-made frame of n falling edges on the second link
    task automatic drive_frame(int n, logic [15:0] w);
        int i;
        @(posedge clk);
        lnk2.serial_enable_line_n <= 1'b0;
        lnk2.host_data_oe_n <= 1'b0;
        lnk2.host_data_out <= w[15];
        for (i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            lnk2.serial_clock <= 1'b0;
            repeat (4) @(posedge clk);
            lnk2.serial_clock <= 1'b1;
            lnk2.host_data_out <= w[14 - (i % 15)];
            if (i == 7 && w[15]) lnk2.host_data_oe_n <= 1'b1;
        end
        repeat (4) @(posedge clk);
        lnk2.serial_enable_line_n <= 1'b1;
        lnk2.host_data_oe_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_regs();
        int a, n;
        chk("mode", 8'h00, {7'h00, dev_mode});
        for (a = 0; a < 16; a++) begin
            xfer(1'b1, CODE, 4'(a), 8'h00);
            chk("reset value", 8'h00, rdata);
        end
        for (a = 0; a < 16; a++) begin
            n = n_stb;
            xfer(1'b0, CODE, 4'(a), {4'(a), ~4'(a)});
            chk("strobes", 8'h01, 8'(n_stb - n));
            chk("wr addr", {4'h0, 4'(a)}, {4'h0, wr_addr});
            chk("wr data", {4'(a), ~4'(a)}, wr_data);
        end
        for (a = 15; a >= 0; a--) begin
            xfer(1'b1, CODE, 4'(a), 8'h00);
            chk("read back", {4'(a), ~4'(a)}, rdata);
        end
        $display("done registers");
    endtask

    task automatic t_bad_code();
        int c, n;
        n = n_stb;
        for (c = 0; c < 8; c++) begin
            if (c != CODE) begin
                xfer(1'b0, 3'(c), 4'h3, 8'hFF);
                xfer(1'b1, 3'(c), 4'h3, 8'h00);
                chk("foreign read", 8'h00, rdata);
            end
        end
        chk("foreign strobes", 8'h00, 8'(n_stb - n));
        xfer(1'b1, CODE, 4'h3, 8'h00);
        chk("kept value", 8'h3C, rdata);
        $display("done select code");
    endtask

    task automatic t_mode();
        xfer(1'b0, CODE, `CTRL_REG, 8'h80);
        chk("mode set", 8'h01, {7'h00, dev_mode});
        mode_inv <= 1'b1;
        xfer(1'b0, CODE, 4'h9, 8'h69);
        chk("inv write", 8'h69, wr_data);
        xfer(1'b1, CODE, 4'h9, 8'h00);
        chk("inv read", 8'h69, rdata);
        xfer(1'b1, CODE, `CTRL_REG, 8'h00);
        chk("ctrl read", 8'h80, rdata);
        xfer(1'b0, CODE, `CTRL_REG, 8'h00);
        chk("mode clear", 8'h00, {7'h00, dev_mode});
        mode_inv <= 1'b0;
        xfer(1'b1, CODE, 4'h9, 8'h00);
        chk("default read", 8'h69, rdata);
        $display("done mode");
    endtask

    task automatic t_abort();
        int n;
        n = n_stb2;
        drive_frame(12, {1'b0, CODE, 4'hC, 8'hA5});
        drive_frame(10, {1'b1, CODE, 4'hC, 8'h00});
        chk("abort strobes", 8'h00, 8'(n_stb2 - n));
        chk("abort release", 8'h01, {7'h00, lnk2.dev_data_oe_n});
        drive_frame(16, {1'b0, CODE, 4'hC, 8'hA5});
        chk("frame strobes", 8'h01, 8'(n_stb2 - n));
        chk("frame data", 8'hA5, wr_data2);
        chk("frame addr", 8'h0C, {4'h0, wr_addr2});
        chk("mode 2", 8'h00, {7'h00, mode2});
        $display("done abort");
    endtask

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        start = 1'b0;
        rd = 1'b0;
        mode_inv = 1'b0;
        sel_code = CODE;
        addr = 4'h0;
        wdata = 8'h00;
        lnk2.serial_clock = 1'b1;
        lnk2.serial_enable_line_n = 1'b1;
        lnk2.host_data_out = 1'b0;
        lnk2.host_data_oe_n = 1'b1;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_regs();
        t_bad_code();
        t_mode();
        t_abort();
        finish_test();
    end
endmodule

`default_nettype wire
